// >>> hw/rai_pkg.sv
// Constants, field layouts and types for the alarm and serial port block.
// Assumes one system clock well above the link and crystal rates.
package rai_pkg;

  // Timekeeping reference, 32.768 kHz
  localparam int XTAL_HZ = 32768;

  localparam logic [5:0] SEC_MAX  = 6'h3B;
  localparam logic [5:0] MIN_MAX  = 6'h3B;
  localparam logic [4:0] HOUR_MAX = 5'h17;
  localparam logic [2:0] DAY_MIN  = 3'h1;
  localparam logic [2:0] DAY_MAX  = 3'h7;

  // Read addresses of the serial port
  localparam logic [6:0] ADDR_SEC    = 7'h00;
  localparam logic [6:0] ADDR_MIN    = 7'h01;
  localparam logic [6:0] ADDR_HOUR   = 7'h02;
  localparam logic [6:0] ADDR_DAY    = 7'h03;
  localparam logic [6:0] ADDR_STATUS = 7'h10;

  // Address byte: bit 7 low means read
  localparam int ADDR_WRITE_BIT = 7;
  localparam int STAT_FLAG_A    = 0;
  localparam int STAT_FLAG_B    = 1;

  // Strap level that picks the 3-wire port
  localparam logic STRAP_3WIRE = 1'b0;

  // Synchroniser lanes
  localparam int SY_XTAL   = 0;
  localparam int SY_SCLK   = 1;
  localparam int SY_CS     = 2;
  localparam int SY_SDI    = 3;
  localparam int SY_STRAP  = 4;
  localparam int SY_LO_BKP = 5;
  localparam int SY_LO_BAT = 6;
  localparam int SYNC_W    = 7;

  typedef struct packed {
    logic [2:0] day;
    logic [4:0] hour;
    logic [5:0] min;
    logic [5:0] sec;
  } rai_time_t;

  // A set mask bit makes that field a don't-care
  typedef struct packed {
    logic       m_day;
    logic [2:0] day;
    logic       m_hour;
    logic [4:0] hour;
    logic       m_min;
    logic [5:0] min;
    logic       m_sec;
    logic [5:0] sec;
  } rai_alarm_t;

  typedef enum logic [1:0] {
    SP_IDLE = 2'b00,
    SP_ADDR = 2'b01,
    SP_DATA = 2'b10
  } rai_sp_state_t;

endpackage

// >>> hw/rai_pin_sync.sv
// Two-flop synchronisers with edge detection, one lane per pin.
// Assumes pins are asynchronous to mclk_in and slower than it.
`timescale 1ns/1ps
`default_nettype none
module rai_pin_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk_in,
  input  wire logic         reset_in,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_out,
  output logic      [W-1:0] rise_out,
  output logic      [W-1:0] fall_out
);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_lane
      logic meta;
      logic stable;
      logic last;
      // Edges look only at the second and third flops
      always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
          meta   <= 1'b0;
          stable <= 1'b0;
          last   <= 1'b0;
        end else begin
          meta   <= pin_in[i];
          stable <= meta;
          last   <= stable;
        end
      end
      assign level_out[i] = stable;
      assign rise_out[i]  = stable & ~last;
      assign fall_out[i]  = ~stable & last;
    end
  endgenerate

endmodule
`default_nettype wire

// >>> hw/rai_alarm_port.sv
// Alarm interrupt pins, port strap, serial read port and supply-fail pin.
// Assumes control bits come from logic on mclk_in; all pins are async.
`timescale 1ns/1ps
`default_nettype none
module rai_alarm_port #(
  parameter int XTAL_DIV = rai_pkg::XTAL_HZ
) (
  input  wire logic               mclk_in,
  input  wire logic               reset_in,
  input  wire logic               crystal_in,
  output logic                    crystal_out,
  input  wire logic               port_style_strap_in,
  input  wire logic               chip_select_in,
  input  wire logic               serial_clk_in,
  input  wire logic               serial_in_in,
  output logic                    serial_out_out,
  output logic                    serial_out_oe_out,
  input  wire logic               irq_routing_select_in,
  input  wire logic               alarm_a_irq_en_in,
  input  wire logic               alarm_b_irq_en_in,
  input  wire rai_pkg::rai_alarm_t alarm_a_in,
  input  wire rai_pkg::rai_alarm_t alarm_b_in,
  input  wire logic               flag_a_clear_in,
  input  wire logic               flag_b_clear_in,
  output logic                    flag_a_out,
  output logic                    flag_b_out,
  output rai_pkg::rai_time_t      time_out,
  output logic                    alarm_irq_a_n_out,
  output logic                    alarm_irq_a_n_oe_out,
  output logic                    alarm_irq_b_n_out,
  output logic                    alarm_irq_b_n_oe_out,
  input  wire logic               primary_below_backup_in,
  input  wire logic               primary_below_battery_in,
  output logic                    supply_fail_n_out
);
  import rai_pkg::*;

  localparam int DIV_W = (XTAL_DIV > 1) ? $clog2(XTAL_DIV) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(XTAL_DIV - 1);

  logic [SYNC_W-1:0] sy_lvl;
  logic [SYNC_W-1:0] sy_rise;
  logic [SYNC_W-1:0] sy_fall;

  rai_pin_sync #(.W(SYNC_W)) u_sync (
    .mclk_in   (mclk_in),
    .reset_in  (reset_in),
    .pin_in    ({primary_below_battery_in, primary_below_backup_in,
                 port_style_strap_in, serial_in_in, chip_select_in,
                 serial_clk_in, crystal_in}),
    .level_out (sy_lvl),
    .rise_out  (sy_rise),
    .fall_out  (sy_fall)
  );

  // Timekeeping
  logic [DIV_W-1:0] div;
  logic [DIV_W-1:0] next_div;
  rai_time_t        now;
  rai_time_t        next_now;
  logic             upd;
  logic             next_upd;

  always_comb begin
    next_div = div;
    next_now = now;
    next_upd = 1'b0;
    if (sy_rise[SY_XTAL]) begin
      if (div == DIV_LAST) begin
        next_div = '0;
        next_upd = 1'b1;
        if (now.sec == SEC_MAX) begin
          next_now.sec = '0;
          if (now.min == MIN_MAX) begin
            next_now.min = '0;
            if (now.hour == HOUR_MAX) begin
              next_now.hour = '0;
              next_now.day  = (now.day == DAY_MAX) ? DAY_MIN
                                                   : now.day + 3'h1;
            end else begin
              next_now.hour = now.hour + 5'h01;
            end
          end else begin
            next_now.min = now.min + 6'h01;
          end
        end else begin
          next_now.sec = now.sec + 6'h01;
        end
      end else begin
        next_div = div + DIV_W'(1);
      end
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      div <= '0;
      now <= '{day: DAY_MIN, hour: 5'h00, min: 6'h00, sec: 6'h00};
      upd <= 1'b0;
    end else begin
      div <= next_div;
      now <= next_now;
      upd <= next_upd;
    end
  end

  // Alarm flags; compare runs the cycle after the time settles
  function automatic logic alarm_hit(input rai_alarm_t a,
                                     input rai_time_t t);
    alarm_hit = (a.m_sec  | (a.sec  == t.sec))  &
                (a.m_min  | (a.min  == t.min))  &
                (a.m_hour | (a.hour == t.hour)) &
                (a.m_day  | (a.day  == t.day));
  endfunction

  logic flag_a;
  logic flag_b;
  logic next_flag_a;
  logic next_flag_b;

  always_comb begin
    // A set in the clearing cycle wins
    next_flag_a = (flag_a & ~flag_a_clear_in) |
                  (upd & alarm_hit(alarm_a_in, now));
    next_flag_b = (flag_b & ~flag_b_clear_in) |
                  (upd & alarm_hit(alarm_b_in, now));
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      flag_a <= 1'b0;
      flag_b <= 1'b0;
    end else begin
      flag_a <= next_flag_a;
      flag_b <= next_flag_b;
    end
  end

  // Pins: interrupts, supply fail, crystal drive
  logic irq_a_on;
  logic irq_b_on;
  logic fail_n;
  logic xtal_drv;
  logic next_irq_a_on;
  logic next_irq_b_on;
  logic next_fail_n;
  logic next_xtal_drv;

  always_comb begin
    // Routing high keeps each alarm on its own pin
    next_irq_a_on = (flag_a & alarm_a_irq_en_in) |
                    (~irq_routing_select_in &
                     flag_b & alarm_b_irq_en_in);
    next_irq_b_on = irq_routing_select_in &
                    flag_b & alarm_b_irq_en_in;
    next_fail_n   = ~(sy_lvl[SY_LO_BKP] | sy_lvl[SY_LO_BAT]);
    next_xtal_drv = ~sy_lvl[SY_XTAL];
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      irq_a_on <= 1'b0;
      irq_b_on <= 1'b0;
      fail_n   <= 1'b1;
      xtal_drv <= 1'b0;
    end else begin
      irq_a_on <= next_irq_a_on;
      irq_b_on <= next_irq_b_on;
      fail_n   <= next_fail_n;
      xtal_drv <= next_xtal_drv;
    end
  end

  // Open drain: only ever drive zero
  assign alarm_irq_a_n_out    = 1'b0;
  assign alarm_irq_b_n_out    = 1'b0;
  assign alarm_irq_a_n_oe_out = irq_a_on;
  assign alarm_irq_b_n_oe_out = irq_b_on;
  assign supply_fail_n_out    = fail_n;
  assign crystal_out          = xtal_drv;
  assign flag_a_out           = flag_a;
  assign flag_b_out           = flag_b;
  assign time_out             = now;

  // Serial read port
  function automatic logic [7:0] rd_byte(input logic [6:0] a);
    case (a)
      ADDR_SEC:    rd_byte = {2'h0, now.sec};
      ADDR_MIN:    rd_byte = {2'h0, now.min};
      ADDR_HOUR:   rd_byte = {3'h0, now.hour};
      ADDR_DAY:    rd_byte = {5'h00, now.day};
      ADDR_STATUS: rd_byte = {6'h00, flag_b, flag_a};
      default:     rd_byte = 8'h00;
    endcase
  endfunction

  rai_sp_state_t st;
  rai_sp_state_t next_st;
  logic [2:0]    bits;
  logic [2:0]    next_bits;
  logic [7:0]    sh;
  logic [7:0]    next_sh;
  logic [7:0]    tx;
  logic [7:0]    next_tx;
  logic [6:0]    addr;
  logic [6:0]    next_addr;
  logic          rd;
  logic          next_rd;
  logic          lsb;
  logic          next_lsb;
  logic          so;
  logic          next_so;
  logic          oe;
  logic          next_oe;
  logic [7:0]    sh_in;

  always_comb begin
    sh_in     = lsb ? {sy_lvl[SY_SDI], sh[7:1]} : {sh[6:0], sy_lvl[SY_SDI]};
    next_st   = st;
    next_bits = bits;
    next_sh   = sh;
    next_tx   = tx;
    next_addr = addr;
    next_rd   = rd;
    next_lsb  = lsb;
    next_so   = so;
    next_oe   = oe;
    if (!sy_lvl[SY_CS]) begin
      next_st = SP_IDLE;
      next_oe = 1'b0;
      next_so = 1'b0;
    end else begin
      case (st)
        SP_IDLE: begin
          next_st   = SP_ADDR;
          next_bits = 3'h0;
          next_rd   = 1'b0;
          next_oe   = 1'b0;
          // 3-wire sends LSB first, SPI MSB first
          next_lsb  = (sy_lvl[SY_STRAP] == STRAP_3WIRE);
        end
        SP_ADDR, SP_DATA: begin
          if (sy_rise[SY_SCLK]) begin
            next_sh   = sh_in;
            next_bits = bits + 3'h1;
            if (bits == 3'h7) begin
              if (st == SP_ADDR) begin
                next_st   = SP_DATA;
                next_addr = sh_in[6:0];
                next_rd   = ~sh_in[ADDR_WRITE_BIT];
                next_tx   = rd_byte(sh_in[6:0]);
              end else begin
                // Burst reads walk the address upward
                next_addr = addr + 7'h01;
                next_tx   = rd_byte(addr + 7'h01);
              end
            end
          end
          if (sy_fall[SY_SCLK] && st == SP_DATA && rd) begin
            next_oe = 1'b1;
            next_so = lsb ? tx[0] : tx[7];
            next_tx = lsb ? {1'b0, tx[7:1]} : {tx[6:0], 1'b0};
          end
        end
        default: begin
          next_st = SP_IDLE;
          next_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      st   <= SP_IDLE;
      bits <= 3'h0;
      sh   <= 8'h00;
      tx   <= 8'h00;
      addr <= 7'h00;
      rd   <= 1'b0;
      lsb  <= 1'b0;
      so   <= 1'b0;
      oe   <= 1'b0;
    end else begin
      st   <= next_st;
      bits <= next_bits;
      sh   <= next_sh;
      tx   <= next_tx;
      addr <= next_addr;
      rd   <= next_rd;
      lsb  <= next_lsb;
      so   <= next_so;
      oe   <= next_oe;
    end
  end

  assign serial_out_out    = so;
  assign serial_out_oe_out = oe;

endmodule
`default_nettype wire

// >>> dv/rai_alarm_port_asserts.sv
// Checker for the alarm pins, supply-fail pin and serial output release.
// Assumes it is bound to rai_alarm_port and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module rai_alarm_port_asserts (
  input wire logic               mclk_in,
  input wire logic               reset_in,
  input wire logic               crystal_in,
  input wire logic               crystal_out,
  input wire logic               chip_select_in,
  input wire logic               serial_out_oe_out,
  input wire logic               irq_routing_select_in,
  input wire logic               alarm_a_irq_en_in,
  input wire logic               alarm_b_irq_en_in,
  input wire rai_pkg::rai_alarm_t alarm_a_in,
  input wire logic               flag_a_out,
  input wire logic               flag_b_out,
  input wire rai_pkg::rai_time_t  time_out,
  input wire logic               alarm_irq_a_n_out,
  input wire logic               alarm_irq_a_n_oe_out,
  input wire logic               alarm_irq_b_n_out,
  input wire logic               alarm_irq_b_n_oe_out,
  input wire logic               primary_below_backup_in,
  input wire logic               primary_below_battery_in,
  input wire logic               supply_fail_n_out
);
  import rai_pkg::*;
  logic cause_a;
  logic cause_b;
  logic share_b;
  logic fail;
  logic all_a;
  assign cause_a = flag_a_out && alarm_a_irq_en_in;
  assign cause_b = flag_b_out && alarm_b_irq_en_in;
  assign share_b = !irq_routing_select_in && cause_b;
  assign fail = primary_below_backup_in || primary_below_battery_in;
  assign all_a = alarm_a_in.m_sec && alarm_a_in.m_min &&
                 alarm_a_in.m_hour && alarm_a_in.m_day;
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (reset_in);
  // A time step, seen one edge after the counters move
  sequence s_tick;
    time_out != $past(time_out);
  endsequence
  sequence s_every_sec_a;
    s_tick ##0 all_a;
  endsequence
  AST_IRQA_HOLD: assert property (cause_a [*2] |-> alarm_irq_a_n_oe_out)
    else $error("first irq pin not pulled low by alarm A");
  AST_IRQA_SHARE: assert property (share_b [*2] |-> alarm_irq_a_n_oe_out)
    else $error("shared routing did not pull first irq pin");
  AST_IRQA_REL: assert property ((!cause_a && !share_b) [*2] |-> !alarm_irq_a_n_oe_out)
    else $error("first irq pin held without cause");
  AST_IRQB_ONLY: assert property (alarm_irq_b_n_oe_out |-> $past(cause_b && irq_routing_select_in))
    else $error("second irq pin pulled without alarm B");
  AST_IRQB_HOLD: assert property ((irq_routing_select_in && cause_b) [*2] |-> alarm_irq_b_n_oe_out)
    else $error("second irq pin not pulled low");
  AST_OPEN_DRAIN: assert property (!alarm_irq_a_n_out && !alarm_irq_b_n_out)
    else $error("irq pin drives a high level");
  AST_FAIL_LOW: assert property (fail [*5] |-> !supply_fail_n_out)
    else $error("supply fail not low");
  AST_FAIL_HIGH: assert property (!fail [*5] |-> supply_fail_n_out)
    else $error("supply fail not high");
  AST_SO_RELEASE: assert property (!chip_select_in [*5] |-> !serial_out_oe_out)
    else $error("serial output driven without chip select");
  AST_SO_IN_FRAME: assert property ($rose(serial_out_oe_out) |-> chip_select_in)
    else $error("serial output driven outside a frame");
  AST_EVERY_SEC: assert property (s_every_sec_a |-> ##[1:3] flag_a_out)
    else $error("masked alarm did not set its flag");
  AST_FLAG_ON_TICK: assert property ($rose(flag_b_out) |-> ($past(time_out) != $past(time_out, 2)) || ($past(time_out, 2) != $past(time_out, 3)))
    else $error("alarm flag set away from a time step");
  AST_XTAL_OUT: assert property (crystal_in [*5] |-> !crystal_out)
    else $error("crystal output not the complement");
endmodule
bind rai_alarm_port rai_alarm_port_asserts u_chk (
  .mclk_in, .reset_in, .crystal_in, .crystal_out, .chip_select_in,
  .serial_out_oe_out, .irq_routing_select_in, .alarm_a_irq_en_in,
  .alarm_b_irq_en_in, .alarm_a_in, .flag_a_out, .flag_b_out, .time_out,
  .alarm_irq_a_n_out, .alarm_irq_a_n_oe_out, .alarm_irq_b_n_out,
  .alarm_irq_b_n_oe_out, .primary_below_backup_in,
  .primary_below_battery_in, .supply_fail_n_out
);
`default_nettype wire

// >>> dv/rai_host_model.sv
// Host serial port: chip select, serial clock and the data line(s).
// Assumes calls start at a falling mclk edge; delays are 40 ns multiples.
`timescale 1ns/1ps
`default_nettype none
module rai_host_model (
  input  wire logic strap_in,
  input  wire logic sout_in,
  input  wire logic soe_in,
  output logic      cs_out,
  output logic      sclk_out,
  output logic      sdi_out
);
  logic mosi    = 1'b0;
  logic host_oe = 1'b0;
  logic tgl     = 1'b0;
  logic line;
  logic miso;
  initial begin
    cs_out = 1'b0;
    sclk_out = 1'b0;
  end
  // Undriven lines toggle so a stale level never passes
  always #40 tgl = ~tgl;
  assign line = soe_in ? sout_in : (host_oe ? mosi : tgl);
  assign sdi_out = strap_in ? (host_oe ? mosi : tgl) : line;
  assign miso = strap_in ? (soe_in ? sout_in : tgl) : line;
  task automatic xfer(input logic [7:0] a, output logic [7:0] d,
                      output logic drove);
    int b;
    d = 8'h00;
    drove = 1'b0;
    cs_out = 1'b1;
    #200;
    for (int i = 0; i < 16; i++) begin
      b = strap_in ? 7 - i % 8 : i % 8;
      host_oe = i < 8 || a[7] || strap_in;
      mosi = i < 8 ? a[b] : 1'b0;
      #160 sclk_out = 1'b1;
      #80 if (i >= 8) d[b] = miso;
      drove = drove | soe_in;
      #80 sclk_out = 1'b0;
    end
    #160 cs_out = 1'b0;
    host_oe = 1'b0;
    #400;
  endtask
endmodule
`default_nettype wire

// >>> dv/tb_rai_alarm_port.sv
// Testbench for rai_alarm_port with a shortened crystal divider.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module tb_rai_alarm_port;
  import rai_pkg::*;
  logic mclk_in = 0, reset_in = 1, crystal_in = 0, port_style_strap_in = 1;
  logic irq_routing_select_in = 1, alarm_a_irq_en_in = 1;
  logic alarm_b_irq_en_in = 1, flag_a_clear_in = 0, flag_b_clear_in = 0;
  logic primary_below_backup_in = 0, primary_below_battery_in = 0;
  rai_alarm_t alarm_a_in = {1'b1, 3'h0, 1'b1, 5'h00, 1'b1, 6'h00, 1'b0, 6'h3B};
  rai_alarm_t alarm_b_in = {1'b1, 3'h0, 1'b1, 5'h00, 1'b1, 6'h00, 1'b0, 6'h02};
  logic chip_select_in, serial_clk_in, serial_in_in, serial_out_out;
  logic serial_out_oe_out, crystal_out, flag_a_out, flag_b_out;
  logic alarm_irq_a_n_out, alarm_irq_a_n_oe_out, supply_fail_n_out;
  logic alarm_irq_b_n_out, alarm_irq_b_n_oe_out;
  rai_time_t time_out;
  int err_count = 0;
  int tests_run = 0;
  always #20 mclk_in = ~mclk_in;
  // Four crystal rises make one second here
  always #400 crystal_in = ~crystal_in;
  rai_alarm_port #(.XTAL_DIV(4)) dut (
    .mclk_in, .reset_in, .crystal_in, .crystal_out, .port_style_strap_in,
    .chip_select_in, .serial_clk_in, .serial_in_in, .serial_out_out,
    .serial_out_oe_out, .irq_routing_select_in, .alarm_a_irq_en_in,
    .alarm_b_irq_en_in, .alarm_a_in, .alarm_b_in, .flag_a_clear_in,
    .flag_b_clear_in, .flag_a_out, .flag_b_out, .time_out,
    .alarm_irq_a_n_out, .alarm_irq_a_n_oe_out, .alarm_irq_b_n_out,
    .alarm_irq_b_n_oe_out, .primary_below_backup_in,
    .primary_below_battery_in, .supply_fail_n_out
  );
  rai_host_model host (
    .strap_in(port_style_strap_in), .sout_in(serial_out_out),
    .soe_in(serial_out_oe_out), .cs_out(chip_select_in),
    .sclk_out(serial_clk_in), .sdi_out(serial_in_in)
  );
  // Wide enough for the reset snapshot, the largest compare
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge mclk_in);
  endtask
  task automatic wrap_up;
    if (err_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic t_supply;
    for (int i = 3; i >= 0; i--) begin
      {primary_below_backup_in, primary_below_battery_in} = 2'(i);
      wait_cyc(6);
      check(supply_fail_n_out, i == 0);
    end
  endtask
  task automatic t_alarm_b;
    for (int n = 0; n < 2000 && flag_b_out !== 1'b1; n++) wait_cyc(1);
    check({time_out.sec, flag_a_out}, {6'h02, 1'b0});
    wait_cyc(2);
    check({alarm_irq_a_n_oe_out, alarm_irq_b_n_oe_out}, 2'b01);
    irq_routing_select_in = 1'b0;
    wait_cyc(2);
    check({alarm_irq_a_n_oe_out, alarm_irq_b_n_oe_out}, 2'b10);
    alarm_b_irq_en_in = 1'b0;
    wait_cyc(2);
    check({alarm_irq_a_n_oe_out, alarm_irq_b_n_oe_out}, 2'b00);
  endtask
  task automatic t_serial;
    logic [7:0] d;
    logic drove;
    for (int s = 1; s >= 0; s--) begin
      port_style_strap_in = s[0];
      wait_cyc(2);
      host.xfer(8'h10, d, drove);
      check({d, drove}, {8'h02, 1'b1});
      host.xfer(8'h03, d, drove);
      check(d, 8'h01);
      host.xfer(8'h7F, d, drove);
      check(d, 8'h00);
      host.xfer(8'h90, d, drove);
      check(drove, 1'b0);
      wait_cyc(6);
      check(serial_out_oe_out, 1'b0);
    end
  endtask
  task automatic t_alarm_a;
    alarm_a_in = {1'b1, 3'h0, 1'b1, 5'h00, 1'b1, 6'h00, 1'b1, 6'h00};
    for (int n = 0; n < 200 && flag_a_out !== 1'b1; n++) wait_cyc(1);
    wait_cyc(2);
    check(alarm_irq_a_n_oe_out, 1'b1);
    alarm_a_irq_en_in = 1'b0;
    wait_cyc(2);
    check(alarm_irq_a_n_oe_out, 1'b0);
    {flag_a_clear_in, flag_b_clear_in} = 2'b11;
    wait_cyc(1);
    {flag_a_clear_in, flag_b_clear_in} = 2'b00;
    wait_cyc(1);
    check({flag_a_out, flag_b_out}, 2'b00);
  endtask
  initial begin
    wait_cyc(2);
    check({alarm_irq_a_n_oe_out, alarm_irq_b_n_oe_out, supply_fail_n_out,
           flag_a_out, flag_b_out, serial_out_oe_out, serial_out_out,
           crystal_out, time_out}, {8'b00100000, 3'h1, 17'h0});
    wait_cyc(14);
    reset_in = 1'b0;
    wait_cyc(4);
    t_supply();
    t_alarm_b();
    t_serial();
    t_alarm_a();
    wrap_up();
  end
  // Whole run is near 60 us
  initial begin
    #500000;
    err_count++;
    wrap_up();
  end
endmodule
`default_nettype wire
